// File: src/lpr_ctrl.v
// Low-power mode, reset scope and standby clock controller with APB registers
`timescale 1ns/1ns
`include "lpr_defines.vh"

// Operation
// [R1] Six reset sources: POR, BOD, watchdogs, wakes
// [R2] POR, BOD, full-chip watchdog reset everything
// [R3] Software sets scoped watchdog reach, chip included
// [R4] Shutdown wake applies full system reset
// [R5] Deep sleep wake resets digital blocks only
// [R6] Four power modes; shutdown lowest consumption
// [R7] Shutdown powers all off; chip enable wakes
// [R8] Deep sleep keeps always-on domain; three wakes
// [R9] Retention register survives deep sleep
// [R10] Sleep gates processor and digital clocks
// [R11] Sleep exits on pin, timer, touch, MAC
// [R12] Active runs processor, all peripherals available
// [R13] Standby clock selected from three sources
// [R14] Resets assert async, release via two flops
module lpr_ctrl
#(
    parameter HOLD_W = 8
)
(
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // Reset sources
    input wire por_detect,
    input wire bod_detect,
    input wire full_chip_watchdog,
    input wire scoped_watchdog,
    input wire chip_enable_pin,
    // Wake events
    input wire wake_pin,
    input wire wake_rtc,
    input wire wake_touch,
    input wire wake_mac,
    // Standby clock sources
    input wire slow_crystal_clock,
    input wire derived_32k_clock,
    input wire ring_oscillator_clock,
    output wire low_power_standby_clock,
    // Power and clock controls
    output reg cpu_run,
    output reg cpu_clk_en,
    output reg dig_clk_en,
    output reg dig_power_on,
    output reg always_on_domain_power_on,
    output reg [1:0] power_mode,
    // Domain resets
    output wire sys_rst_n,
    output wire dig_rst_n,
    output wire periph_rst_n,
    // Interrupt
    output wire irq
);

localparam integer HOLD_NUM = (`LPR_RST_HOLD_NS + `LPR_CLK_PERIOD_NS - 1) / `LPR_CLK_PERIOD_NS;
localparam [HOLD_W-1:0] RST_HOLD_CYC = HOLD_NUM[HOLD_W-1:0];

localparam [3:0] ST_ACTIVE = 4'h1;
localparam [3:0] ST_SLEEP = 4'h2;
localparam [3:0] ST_DEEP = 4'h4;
localparam [3:0] ST_SHUT = 4'h8;

reg [3:0] state;
reg [3:0] next_state;
reg [3:0] wake_en;
reg [2:0] scope;
reg [1:0] lpo_sel;
reg [31:0] retain;
reg [3:0] irq_stat;
reg [3:0] irq_en;
reg [2:0] cause;
reg chip_en_q;
reg sdog_q;
reg [2:0] dom_req;
reg [2:0] dom_hold;
reg [HOLD_W*3-1:0] hold_cnt;

wire wr_en;
wire rd_setup;
wire addr_ok;
wire chip_en_rise;
wire sdog_rise;
wire full_src;
wire sdog_chip;
wire shut_wake;
wire sleep_wake;
wire deep_wake;
wire full_req;
wire dig_req;
wire periph_req;
wire mode_wr;
wire [3:0] irq_set;
wire [3:0] irq_clr;
wire [2:0] dom_arst_n;
wire [2:0] dom_rst_n;

// Single-cycle access phase, so no wait state ever
assign pready = 1'b1;
assign addr_ok = (paddr == `LPR_OFF_CTRL) || (paddr == `LPR_OFF_STATUS) ||
    (paddr == `LPR_OFF_WAKE_EN) || (paddr == `LPR_OFF_SCOPE) ||
    (paddr == `LPR_OFF_LPO_SEL) || (paddr == `LPR_OFF_RETAIN) ||
    (paddr == `LPR_OFF_IRQ_STAT) || (paddr == `LPR_OFF_IRQ_CLR) ||
    (paddr == `LPR_OFF_IRQ_EN);
assign pslverr = psel && penable && !addr_ok;
assign wr_en = psel && penable && pwrite && addr_ok;
assign rd_setup = psel && !penable && !pwrite;

// Edge detection on synchronous inputs
assign chip_en_rise = chip_enable_pin && !chip_en_q;
assign sdog_rise = scoped_watchdog && !sdog_q;

assign full_src = por_detect || bod_detect || full_chip_watchdog; // [R1] [R2]
assign sdog_chip = sdog_rise && scope[`LPR_DOM_CHIP]; // [R3]
assign shut_wake = state[3] && chip_en_rise; // [R7] [R4]
assign sleep_wake = state[1] && ((wake_pin && wake_en[`LPR_WK_PIN]) ||
    (wake_rtc && wake_en[`LPR_WK_RTC]) ||
    (wake_touch && wake_en[`LPR_WK_TOUCH]) ||
    (wake_mac && wake_en[`LPR_WK_MAC])); // [R11]
// MAC counters are powered down in deep sleep, so they cannot wake it
assign deep_wake = state[2] && ((wake_pin && wake_en[`LPR_WK_PIN]) ||
    (wake_rtc && wake_en[`LPR_WK_RTC]) ||
    (wake_touch && wake_en[`LPR_WK_TOUCH])); // [R8]

assign full_req = full_src || sdog_chip || shut_wake; // [R2] [R4]
// Deep wake reaches digital and peripheral domains only; always-on logic keeps its state
assign dig_req = full_req || deep_wake ||
    (sdog_rise && scope[`LPR_DOM_DIG]); // [R5] [R3]
assign periph_req = dig_req || (sdog_rise && scope[`LPR_DOM_PERIPH]); // [R3]

assign mode_wr = wr_en && (paddr == `LPR_OFF_CTRL) && state[0];

assign irq_set[`LPR_IRQ_SLEEP_WAKE] = sleep_wake;
assign irq_set[`LPR_IRQ_DEEP_WAKE] = deep_wake;
assign irq_set[`LPR_IRQ_SCOPED_WDT] = sdog_rise;
assign irq_set[`LPR_IRQ_MODE_ENTER] = mode_wr &&
    (pwdata[1:0] != `LPR_MODE_ACTIVE);
assign irq_clr = (wr_en && (paddr == `LPR_OFF_IRQ_CLR)) ? pwdata[3:0] : 4'h0;
assign irq = |(irq_stat & irq_en);

// Standby clock selector; a glitch-free switch is left to the clock cell
assign low_power_standby_clock = (lpo_sel == `LPR_LPO_XTAL) ? slow_crystal_clock :
    (lpo_sel == `LPR_LPO_DERIVED) ? derived_32k_clock :
    ring_oscillator_clock; // [R13]

always @*
begin
    next_state = state;
    case (state)
        ST_ACTIVE:
        begin
            if (mode_wr)
            begin
                case (pwdata[1:0])
                    `LPR_MODE_SLEEP: next_state = ST_SLEEP;
                    `LPR_MODE_DEEP: next_state = ST_DEEP;
                    `LPR_MODE_SHUT: next_state = ST_SHUT;
                    default: next_state = ST_ACTIVE;
                endcase
            end
        end
        ST_SLEEP:
        begin
            if (sleep_wake)
                next_state = ST_ACTIVE; // [R11]
        end
        ST_DEEP:
        begin
            if (deep_wake)
                next_state = ST_ACTIVE; // [R8]
        end
        ST_SHUT:
        begin
            if (shut_wake)
                next_state = ST_ACTIVE; // [R7]
        end
        default: next_state = ST_ACTIVE;
    endcase
    if (full_req)
        next_state = ST_ACTIVE;
end

// Mode state and derived power/clock controls
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_ACTIVE;
        power_mode <= `LPR_MODE_ACTIVE;
        cpu_run <= 1'b1;
        cpu_clk_en <= 1'b1;
        dig_clk_en <= 1'b1;
        dig_power_on <= 1'b1;
        always_on_domain_power_on <= 1'b1;
        chip_en_q <= 1'b0;
        sdog_q <= 1'b0;
    end
    else
    begin
        state <= next_state; // [R6]
        chip_en_q <= chip_enable_pin;
        sdog_q <= scoped_watchdog;
        cpu_run <= next_state[0]; // [R12]
        cpu_clk_en <= next_state[0]; // [R10]
        dig_clk_en <= next_state[0]; // [R10]
        dig_power_on <= next_state[0] || next_state[1]; // [R8]
        always_on_domain_power_on <= !next_state[3]; // [R7]
        case (next_state)
            ST_SLEEP: power_mode <= `LPR_MODE_SLEEP;
            ST_DEEP: power_mode <= `LPR_MODE_DEEP;
            ST_SHUT: power_mode <= `LPR_MODE_SHUT;
            default: power_mode <= `LPR_MODE_ACTIVE;
        endcase
    end
end

// Configuration registers; a full reset request returns them to defaults
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        wake_en <= `LPR_RST_WAKE_EN;
        scope <= `LPR_RST_SCOPE;
        lpo_sel <= `LPR_RST_LPO_SEL;
        retain <= `LPR_RST_RETAIN;
        irq_en <= 4'h0;
    end
    else if (full_req)
    begin
        wake_en <= `LPR_RST_WAKE_EN; // [R2]
        scope <= `LPR_RST_SCOPE;
        lpo_sel <= `LPR_RST_LPO_SEL;
        retain <= `LPR_RST_RETAIN;
        irq_en <= 4'h0;
    end
    else if (wr_en)
    begin
        case (paddr)
            `LPR_OFF_WAKE_EN: wake_en <= pwdata[3:0];
            `LPR_OFF_SCOPE: scope <= pwdata[2:0]; // [R3]
            `LPR_OFF_LPO_SEL: lpo_sel <= pwdata[1:0]; // [R13]
            `LPR_OFF_RETAIN: retain <= pwdata; // [R9]
            `LPR_OFF_IRQ_EN: irq_en <= pwdata[3:0];
            default: irq_en <= irq_en;
        endcase
    end
end

// Sticky status; a set in the same cycle as a clear wins
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        irq_stat <= 4'h0;
    else if (full_req)
        irq_stat <= 4'h0;
    else
        irq_stat <= (irq_stat & ~irq_clr) | irq_set;
end

// Last reset cause survives the full reset it describes
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        cause <= `LPR_CAUSE_POR;
    else if (por_detect)
        cause <= `LPR_CAUSE_POR; // [R1]
    else if (bod_detect)
        cause <= `LPR_CAUSE_BOD; // [R1]
    else if (full_chip_watchdog)
        cause <= `LPR_CAUSE_FULL_WDT; // [R1]
    else if (sdog_rise)
        cause <= `LPR_CAUSE_SCOPED_WDT; // [R1]
    else if (shut_wake)
        cause <= `LPR_CAUSE_SHUT_WAKE; // [R1]
    else if (deep_wake)
        cause <= `LPR_CAUSE_DEEP_WAKE; // [R1]
end

// Read data captured in the setup phase
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
        case (paddr)
            `LPR_OFF_CTRL: prdata <= {30'h0, power_mode};
            `LPR_OFF_STATUS: prdata <= {21'h0, dom_hold, 1'b0, cause, 2'h0, power_mode};
            `LPR_OFF_WAKE_EN: prdata <= {28'h0, wake_en};
            `LPR_OFF_SCOPE: prdata <= {29'h0, scope};
            `LPR_OFF_LPO_SEL: prdata <= {30'h0, lpo_sel};
            `LPR_OFF_RETAIN: prdata <= retain;
            `LPR_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat};
            `LPR_OFF_IRQ_EN: prdata <= {28'h0, irq_en};
            default: prdata <= 32'h0000_0000;
        endcase
    end
end

// Domain request vector: digital, peripheral, whole chip
always @*
begin
    dom_req = 3'h0;
    dom_req[`LPR_DOM_DIG] = dig_req;
    dom_req[`LPR_DOM_PERIPH] = periph_req;
    dom_req[`LPR_DOM_CHIP] = full_req;
end

// Per-domain hold counter and synchronized release
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_dom
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                hold_cnt[gi*HOLD_W +: HOLD_W] <= RST_HOLD_CYC;
                dom_hold[gi] <= 1'b1;
            end
            else if (dom_req[gi])
            begin
                hold_cnt[gi*HOLD_W +: HOLD_W] <= RST_HOLD_CYC;
                dom_hold[gi] <= 1'b1;
            end
            else if (hold_cnt[gi*HOLD_W +: HOLD_W] != {HOLD_W{1'b0}})
            begin
                hold_cnt[gi*HOLD_W +: HOLD_W] <=
                    hold_cnt[gi*HOLD_W +: HOLD_W] - {{(HOLD_W-1){1'b0}}, 1'b1};
                dom_hold[gi] <= 1'b1;
            end
            else
                dom_hold[gi] <= 1'b0;
        end

        // Hold comes from a flop, so the async clear input cannot glitch
        assign dom_arst_n[gi] = presetn && !dom_hold[gi]; // [R14]

        lpr_rst_sync u_sync
        (
            .clk(pclk),
            .arst_n(dom_arst_n[gi]),
            .rst_n(dom_rst_n[gi])
        ); // [R14]
    end
endgenerate

assign dig_rst_n = dom_rst_n[`LPR_DOM_DIG];
assign periph_rst_n = dom_rst_n[`LPR_DOM_PERIPH];
assign sys_rst_n = dom_rst_n[`LPR_DOM_CHIP];

endmodule

// File: src/lpr_defines.vh
// Constants for the low-power mode and reset controller
`ifndef LPR_DEFINES_VH
`define LPR_DEFINES_VH

// Register byte offsets
`define LPR_OFF_CTRL 8'h00
`define LPR_OFF_STATUS 8'h04
`define LPR_OFF_WAKE_EN 8'h08
`define LPR_OFF_SCOPE 8'h0c
`define LPR_OFF_LPO_SEL 8'h10
`define LPR_OFF_RETAIN 8'h14
`define LPR_OFF_IRQ_STAT 8'h18
`define LPR_OFF_IRQ_CLR 8'h1c
`define LPR_OFF_IRQ_EN 8'h20

// Power mode codes
`define LPR_MODE_ACTIVE 2'h0
`define LPR_MODE_SLEEP 2'h1
`define LPR_MODE_DEEP 2'h2
`define LPR_MODE_SHUT 2'h3

// Reset cause codes
`define LPR_CAUSE_NONE 3'h0
`define LPR_CAUSE_POR 3'h1
`define LPR_CAUSE_BOD 3'h2
`define LPR_CAUSE_FULL_WDT 3'h3
`define LPR_CAUSE_SCOPED_WDT 3'h4
`define LPR_CAUSE_SHUT_WAKE 3'h5
`define LPR_CAUSE_DEEP_WAKE 3'h6

// Wake source bits
`define LPR_WK_PIN 0
`define LPR_WK_RTC 1
`define LPR_WK_TOUCH 2
`define LPR_WK_MAC 3

// Reset domain / scope bits
`define LPR_DOM_DIG 0
`define LPR_DOM_PERIPH 1
`define LPR_DOM_CHIP 2

// Standby clock select codes
`define LPR_LPO_XTAL 2'h0
`define LPR_LPO_DERIVED 2'h1
`define LPR_LPO_RING 2'h2

// Interrupt status bits
`define LPR_IRQ_SLEEP_WAKE 0
`define LPR_IRQ_DEEP_WAKE 1
`define LPR_IRQ_SCOPED_WDT 2
`define LPR_IRQ_MODE_ENTER 3

// Status field positions
`define LPR_ST_MODE_LSB 0
`define LPR_ST_CAUSE_LSB 4
`define LPR_ST_HOLD_LSB 8

// Reset values
`define LPR_RST_WAKE_EN 4'hf
`define LPR_RST_SCOPE 3'h1
`define LPR_RST_LPO_SEL 2'h2
`define LPR_RST_RETAIN 32'h0000_0000

// Timing
`define LPR_CLK_PERIOD_NS 100
`define LPR_RST_HOLD_NS 1000

`endif

// File: src/lpr_rst_sync.v
// Reset synchronizer: asynchronous assert, two-stage synchronous release
`timescale 1ns/1ns
module lpr_rst_sync
(
    // Clock and asynchronous reset request
    input wire clk,
    input wire arst_n,
    // Synchronized reset
    output reg rst_n
);

reg stage1;

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        stage1 <= 1'b0;
        rst_n <= 1'b0;
    end
    else
    begin
        stage1 <= 1'b1;
        rst_n <= stage1;
    end
end

endmodule

// File: tb/lpr_ctrl_asserts.sv
// Port checker for the low-power reset controller
`timescale 1ns/1ns
`include "lpr_defines.vh"
module lpr_ctrl_asserts
(
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Requests
    input wire por_detect,
    input wire chip_enable_pin,
    // Controls and resets
    input wire cpu_run,
    input wire cpu_clk_en,
    input wire dig_clk_en,
    input wire dig_power_on,
    input wire always_on_domain_power_on,
    input wire [1:0] power_mode,
    input wire sys_rst_n,
    input wire dig_rst_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_act;
        power_mode == `LPR_MODE_ACTIVE |-> cpu_run && cpu_clk_en && dig_clk_en;
    endproperty
    a_act: assert property (p_act) else $error("active gating");
    property p_slp;
        power_mode == `LPR_MODE_SLEEP |-> !cpu_clk_en && !dig_clk_en && dig_power_on;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep gating");
    property p_deep;
        power_mode == `LPR_MODE_DEEP |-> !dig_power_on && always_on_domain_power_on;
    endproperty
    a_deep: assert property (p_deep) else $error("deep power");
    property p_shut;
        power_mode == `LPR_MODE_SHUT |-> !always_on_domain_power_on && !cpu_run;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown power");
    property p_full;
        por_detect |=> !sys_rst_n && !dig_rst_n && power_mode == `LPR_MODE_ACTIVE;
    endproperty
    a_full: assert property (p_full) else $error("full reset");
    // Release needs the hold count plus two sync flops, so eight is a safe floor
    property p_hold;
        por_detect |=> !sys_rst_n [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("early release");
    property p_exit;
        $changed(power_mode) && $past(power_mode) != `LPR_MODE_ACTIVE
            |-> power_mode == `LPR_MODE_ACTIVE;
    endproperty
    a_exit: assert property (p_exit) else $error("bad mode step");
    property p_wake_rst;
        $rose(chip_enable_pin) && power_mode == `LPR_MODE_SHUT |-> ##[1:3] !sys_rst_n;
    endproperty
    a_wake_rst: assert property (p_wake_rst) else $error("no wake reset");
    cover property (power_mode == `LPR_MODE_SLEEP);
    cover property (power_mode == `LPR_MODE_DEEP);
    cover property (power_mode == `LPR_MODE_SHUT);
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the low-power reset controller
`timescale 1ns/1ns
`include "lpr_defines.vh"
module tb_top;
    reg pclk, presetn, psel, penable, pwrite, scoped_watchdog, chip_enable_pin, er;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd, ret, ist, we, sc, ls, ie, cause;
    reg [2:0] fr, ck, lo;
    reg [3:0] wk;
    wire pready, pslverr, irq, cpu_run, cpu_clk_en, dig_clk_en, dig_power_on, lpc;
    wire always_on_domain_power_on, sys_rst_n, dig_rst_n, periph_rst_n;
    wire [31:0] prdata;
    wire [1:0] power_mode;
    integer fail_count, num_checks, i, j, n;
    lpr_ctrl u_lpr_ctrl
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .por_detect(fr[0]), .bod_detect(fr[1]), .full_chip_watchdog(fr[2]),
        .scoped_watchdog, .chip_enable_pin, .wake_pin(wk[0]), .wake_rtc(wk[1]),
        .wake_touch(wk[2]), .wake_mac(wk[3]), .slow_crystal_clock(ck[0]),
        .derived_32k_clock(ck[1]), .ring_oscillator_clock(ck[2]),
        .low_power_standby_clock(lpc), .cpu_run, .cpu_clk_en, .dig_clk_en, .dig_power_on,
        .always_on_domain_power_on, .power_mode, .sys_rst_n, .dig_rst_n, .periph_rst_n,
        .irq
    );
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task tmo;
        begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: wait ran out", $time);
            results;
        end
    endtask
    task chk(input [32:0] g, input [32:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50)
            begin
                n = n + 1;
                @(posedge pclk);
            end
            if (pready !== 1'b1)
                tmo;
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Model of the register file
    function [31:0] rv(input [7:0] a);
        begin
            case (a)
                `LPR_OFF_STATUS: rv = cause << `LPR_ST_CAUSE_LSB;
                `LPR_OFF_WAKE_EN: rv = we;
                `LPR_OFF_SCOPE: rv = sc;
                `LPR_OFF_LPO_SEL: rv = ls;
                `LPR_OFF_RETAIN: rv = ret;
                `LPR_OFF_IRQ_STAT: rv = ist;
                `LPR_OFF_IRQ_EN: rv = ie;
                default: rv = 32'h0;
            endcase
        end
    endfunction
    task mfull(input [31:0] c);
        begin
            we = 32'hf;
            sc = 32'h1;
            ls = 32'h2;
            ret = 32'h0;
            ist = 32'h0;
            ie = 32'h0;
            cause = c;
        end
    endtask
    task rchk(input [7:0] a);
        begin
            apb(a, 1'b0, 32'h0);
            chk({er, rd}, {a > 8'h20, rv(a)});
        end
    endtask
    task allregs;
        begin
            for (i = 0; i <= 36; i = i + 4)
                rchk(i[7:0]);
        end
    endtask
    task wpm(input [1:0] m);
        begin
            n = 0;
            while (power_mode !== m && n < 20)
            begin
                @(posedge pclk);
                n = n + 1;
            end
            if (power_mode !== m)
                tmo;
        end
    endtask
    task wup;
        begin
            n = 0;
            while (!(sys_rst_n === 1'b1 && dig_rst_n === 1'b1 && periph_rst_n === 1'b1)
                && n < 100)
            begin
                @(posedge pclk);
                n = n + 1;
            end
            if (!(sys_rst_n === 1'b1 && dig_rst_n === 1'b1 && periph_rst_n === 1'b1))
                tmo;
        end
    endtask
    // Collects which domain resets went low in the next four cycles
    task samp;
        begin
            lo = 3'h0;
            repeat (4)
            begin
                @(posedge pclk);
                scoped_watchdog <= 1'b0;
                lo = lo | {~sys_rst_n, ~dig_rst_n, ~periph_rst_n};
            end
        end
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, scoped_watchdog, chip_enable_pin} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        fr = 3'h0;
        wk = 4'h0;
        ck = 3'h0;
        fail_count = 0;
        num_checks = 0;
        i = $urandom(50);
        mfull(`LPR_CAUSE_POR);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wup;
        allregs;
        $display("test reset values done");
        for (j = 0; j < 3; j = j + 1)
        begin
            ret = $urandom;
            apb(`LPR_OFF_RETAIN, 1'b1, ret);
            fr <= 3'h1 << j;
            @(posedge pclk);
            fr <= 3'h0;
            @(posedge pclk);
            wup;
            chk({32'h0, n >= 10 && n <= 14}, 33'h1);
            mfull(j + 1);
            allregs;
        end
        $display("test full resets done");
        for (i = 0; i < 4; i = i + 1)
        begin
            ls = i;
            apb(`LPR_OFF_LPO_SEL, 1'b1, ls);
            repeat (3)
            begin
                rd = $urandom;
                ck <= rd[2:0];
                @(posedge pclk);
                chk({32'h0, lpc}, {32'h0, ck[i > 2 ? 2 : i]});
            end
        end
        $display("test standby clock done");
        ie = 32'hf;
        apb(`LPR_OFF_IRQ_EN, 1'b1, ie);
        for (i = 0; i < 4; i = i + 1)
        begin
            apb(`LPR_OFF_CTRL, 1'b1, 32'h1);
            ist = ist | 32'h8;
            wpm(`LPR_MODE_SLEEP);
            wk <= 4'h1 << i;
            @(posedge pclk);
            wk <= 4'h0;
            wpm(`LPR_MODE_ACTIVE);
            ist = ist | 32'h1;
            chk({32'h0, irq}, {32'h0, |(ist & ie)});
        end
        we = 32'h7;
        apb(`LPR_OFF_WAKE_EN, 1'b1, we);
        apb(`LPR_OFF_CTRL, 1'b1, 32'h1);
        wk <= 4'h8;
        repeat (3) @(posedge pclk);
        chk({31'h0, power_mode}, 33'h1);
        apb(`LPR_OFF_CTRL, 1'b1, 32'h3);
        @(posedge pclk);
        chk({31'h0, power_mode}, 33'h1);
        wk <= 4'h2;
        wpm(`LPR_MODE_ACTIVE);
        wk <= 4'h0;
        allregs;
        apb(`LPR_OFF_IRQ_CLR, 1'b1, 32'hf);
        ist = 32'h0;
        apb(`LPR_OFF_CTRL, 1'b1, 32'h0);
        @(posedge pclk);
        chk({31'h0, power_mode}, 33'h0);
        chk({32'h0, irq}, {32'h0, |(ist & ie)});
        $display("test sleep done");
        we = 32'hf;
        apb(`LPR_OFF_WAKE_EN, 1'b1, we);
        ret = $urandom;
        apb(`LPR_OFF_RETAIN, 1'b1, ret);
        apb(`LPR_OFF_CTRL, 1'b1, 32'h2);
        wk <= 4'h8;
        repeat (3) @(posedge pclk);
        chk({31'h0, power_mode}, 33'h2);
        wk <= 4'h4;
        wpm(`LPR_MODE_ACTIVE);
        wk <= 4'h0;
        samp;
        chk({30'h0, lo}, 33'h3);
        wup;
        ist = 32'ha;
        cause = `LPR_CAUSE_DEEP_WAKE;
        allregs;
        $display("test deep sleep done");
        for (j = 0; j < 3; j = j + 1)
        begin
            sc = (j == 2) ? 32'h4 : 32'h2 >> j;
            apb(`LPR_OFF_SCOPE, 1'b1, sc);
            scoped_watchdog <= 1'b1;
            samp;
            chk({30'h0, lo}, (j == 2) ? 33'h7 : 33'h3 >> (1 - j));
            wup;
            cause = `LPR_CAUSE_SCOPED_WDT;
            ist = ist | 32'h4;
            if (j == 2)
                mfull(cause);
            rchk(`LPR_OFF_RETAIN);
            rchk(`LPR_OFF_STATUS);
            rchk(`LPR_OFF_IRQ_STAT);
        end
        $display("test scoped watchdog done");
        ret = $urandom;
        apb(`LPR_OFF_RETAIN, 1'b1, ret);
        apb(`LPR_OFF_CTRL, 1'b1, 32'h3);
        wpm(`LPR_MODE_SHUT);
        chk({32'h0, always_on_domain_power_on}, 33'h0);
        chip_enable_pin <= 1'b1;
        wpm(`LPR_MODE_ACTIVE);
        samp;
        chk({30'h0, lo}, 33'h7);
        wup;
        chip_enable_pin <= 1'b0;
        mfull(`LPR_CAUSE_SHUT_WAKE);
        allregs;
        $display("test shutdown done");
        results;
    end
endmodule
bind lpr_ctrl lpr_ctrl_asserts u_lpr_ctrl_asserts
(
    .pclk, .presetn, .por_detect, .chip_enable_pin, .cpu_run, .cpu_clk_en, .dig_clk_en,
    .dig_power_on, .always_on_domain_power_on, .power_mode, .sys_rst_n, .dig_rst_n
);
